// ---- bench/fifo_status_ctrl_chk.sv ----
// port assertions for the status and data fifo control
`default_nettype none
module fifo_status_ctrl_chk
   import fifo_if_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire bus_req_t   bus_req,
   input wire logic       bus_wait,
   input wire logic [7:0] bus_rdata,
   input wire logic       bus_rvalid,
   input wire logic       exec_start,
   input wire logic       exec_abort,
   input wire logic       exec_abort_ack,
   input wire logic       state_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // access kinds decoded from the request
   wire logic sts_wr  = bus_req.wr && !bus_req.sel_data;
   wire logic data_wr = bus_req.wr && bus_req.sel_data;
   wire logic go_wr   = sts_wr && bus_req.wdata[EXECUTE_BIT];
   wire logic sts_rd  = bus_req.rd && !bus_req.sel_data;
   a_byte_drops_ready: assert property (
      state_ready && data_wr |=> !state_ready) else $error("ready kept after command byte");
   a_ready_write_holds: assert property (
      state_ready && sts_wr && bus_req.wdata[CMD_READY_BIT] |=> state_ready)
      else $error("ready left on a ready write");
   a_go_causes_start: assert property (
      exec_start |-> $past(go_wr)) else $error("start without a go write");
   a_zero_go_quiet: assert property (
      sts_wr && !bus_req.wdata[EXECUTE_BIT] |=> !exec_start) else $error("start on zero go");
   a_start_one_pulse: assert property (
      exec_start |=> !exec_start) else $error("start longer than one cycle");
   a_read_answered: assert property (
      bus_req.rd |=> bus_rvalid) else $error("read not answered");
   a_wo_bits_zero: assert property (
      sts_rd |=> !bus_rdata[EXECUTE_BIT] && !bus_rdata[RESP_RETRY_BIT])
      else $error("write-only status bit read as one");
   a_wait_needs_write: assert property (
      bus_wait |-> $past(data_wr)) else $error("wait state without data write");
   a_abort_held: assert property (
      exec_abort && !exec_abort_ack |=> exec_abort) else $error("abort dropped before ack");
endmodule : fifo_status_ctrl_chk
bind fifo_status_ctrl fifo_status_ctrl_chk u_chk (.ref_clk, .rst, .bus_req, .bus_wait,
   .bus_rdata, .bus_rvalid, .exec_start, .exec_abort, .exec_abort_ack, .state_ready);
`default_nettype wire

// ---- bench/fw_model.sv ----
// firmware stand-in that answers execute and abort requests
`default_nettype none
module fw_model
#(
   parameter int LAT = 10
)(
   input  wire logic  ref_clk,
   input  wire logic  rst,
   input  wire logic  exec_start,
   input  wire logic  exec_abort,
   output logic       exec_done,
   output logic       exec_abort_ack,
   output logic       resp_we,
   output logic [7:0] resp_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] cnt_reg;
   // three response bytes after LAT cycles, done only after the last one
   always_ff @(posedge ref_clk)
   begin
      resp_we <= cnt_reg >= 6'(LAT) && cnt_reg < 6'(LAT + 3);
      resp_wdata <= 8'hA0 + 8'(cnt_reg - 6'(LAT));
      exec_done <= cnt_reg == 6'(LAT + 3);
      exec_abort_ack <= exec_abort && !exec_abort_ack;
      if (rst || exec_abort || cnt_reg == 6'(LAT + 3))
         cnt_reg <= '0;
      else if (exec_start || cnt_reg != '0)
         cnt_reg <= cnt_reg + 6'd1;
   end
endmodule : fw_model
`default_nettype wire

// ---- bench/secure_module_fifo_status_control_test.sv ----
// self-checking bench for the status and data fifo control
`default_nettype none
module secure_module_fifo_status_control_test;
   import fifo_if_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic       ref_clk, rst, bus_wait, bus_rvalid, exec_start, exec_done, exec_abort;
   logic       exec_abort_ack, resp_we, self_test_complete, state_ready;
   logic [7:0] bus_rdata, resp_wdata, q;
   logic [5:0] cmd_len;
   bus_req_t   bus_req;
   int         n_mismatch = 0;
   int         samples_checked = 0;
   fifo_status_ctrl u_dut (.ref_clk, .rst, .bus_req, .bus_wait, .bus_rdata, .bus_rvalid,
      .exec_start, .exec_done, .exec_abort_ack, .exec_abort, .cmd_len, .resp_we,
      .resp_wdata, .self_test_complete, .state_ready);
   fw_model u_fw (.ref_clk, .rst, .exec_start, .exec_abort, .exec_done, .exec_abort_ack,
      .resp_we, .resp_wdata);
   // 200 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic tally_and_finish();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic s, input logic [7:0] d);
      @(negedge ref_clk) bus_req <= '{1'b1, 1'b0, s, d};
      @(negedge ref_clk) bus_req <= '0;
   endtask : wr
   task automatic rd(input logic s, output logic [7:0] d);
      int i;
      @(negedge ref_clk) bus_req <= '{1'b0, 1'b1, s, 8'h00};
      @(negedge ref_clk) bus_req <= '0;
      for (i = 0; i < 3 && bus_rvalid !== 1'b1; i++)
         @(negedge ref_clk);
      if (i == 3)
      begin
         chk({7'h0, bus_rvalid}, 8'h01);
         tally_and_finish();
      end
      d = bus_rdata;
   endtask : rd
   // status read repeated until valid and matching, at most n times
   task automatic poll(input logic [7:0] m, input logic [7:0] v, input int n);
      int i;
      logic [7:0] s;
      for (i = 0; i < n; i++)
      begin
         @(negedge ref_clk);
         rd(1'b0, s);
         if (s[7] === 1'b1 && (s & m) === v)
            break;
      end
      chk(s[7] ? s & m : ~v, v);
      if (i == n)
         tally_and_finish();
   endtask : poll
   task automatic send_cmd();
      logic [7:0] cmd [10] = '{8'h80, 8'h01, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h00, 8'h00,
         8'h01, 8'h43};
      for (int i = 0; i < 10; i++)
      begin
         wr(1'b1, cmd[i]);
         if (i == 0)
            poll(8'h48, 8'h08, 1);
         if (i == 8)
            poll(8'h08, 8'h08, 1);
      end
      poll(8'h08, 8'h00, 8);
      chk(8'(cmd_len), 8'h0A);
   endtask : send_cmd
   // hang guard
   initial
   begin
      repeat (50000) @(posedge ref_clk);
      chk(8'h00, 8'h01);
      tally_and_finish();
   end
   // main sequence
   initial
   begin
      rst = 1'b1;
      bus_req = '0;
      self_test_complete = 1'b0;
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      poll(8'h66, 8'h00, 1);
      wr(1'b0, 8'h00);
      poll(8'h40, 8'h00, 1);
      @(negedge ref_clk) self_test_complete = 1'b1;
      @(negedge ref_clk) self_test_complete = 1'b0;
      wr(1'b0, 8'h00);
      poll(8'h04, 8'h04, 8);
      wr(1'b0, 8'h40);
      poll(8'h40, 8'h40, 600);
      wr(1'b0, 8'h40);
      poll(8'h40, 8'h40, 1);
      chk({7'h0, state_ready}, 8'h01);
      send_cmd();
      wr(1'b0, 8'h00);
      wr(1'b0, 8'h20);
      poll(8'h10, 8'h00, 1);
      poll(8'h10, 8'h10, 60);
      for (int i = 0; i < 3; i++)
      begin
         rd(1'b1, q);
         chk(q, 8'hA0 + 8'(i));
      end
      poll(8'h10, 8'h00, 8);
      rd(1'b1, q);
      chk(q, 8'hFF);
      wr(1'b0, 8'h02);
      poll(8'h10, 8'h10, 8);
      rd(1'b1, q);
      chk(q, 8'hA0);
      wr(1'b0, 8'h40);
      poll(8'h10, 8'h00, 1);
      poll(8'h40, 8'h40, 600);
      send_cmd();
      wr(1'b0, 8'h20);
      wr(1'b0, 8'h40);
      poll(8'h50, 8'h00, 8);
      wr(1'b0, 8'h40);
      poll(8'h40, 8'h40, 600);
      wr(1'b1, 8'h80);
      wr(1'b0, 8'h40);
      poll(8'h48, 8'h00, 8);
      tally_and_finish();
   end
endmodule : secure_module_fifo_status_control_test
`default_nettype wire

// ---- src/byte_store.sv ----
// byte store indexed by a pointer, used for the command and response buffers
`default_nettype none
module byte_store
   import fifo_if_pkg::*;
#(
   parameter int DEPTH = 64,
   parameter int AW    = $clog2(DEPTH)
)(
   input  wire logic          ref_clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [7:0]    wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [7:0]    rdata
);
   logic [7:0] mem_reg [DEPTH];

   // write port
   always_ff @(posedge ref_clk)
   begin
      if (we)
      begin
         mem_reg[waddr] <= wdata;
      end
   end

   assign rdata = mem_reg[raddr];
endmodule : byte_store
`default_nettype wire

// ---- src/fifo_if_pkg.sv ----
// constants, types and state encoding for the command fifo interface
`default_nettype none
package fifo_if_pkg;
   // ***********************************
   // status register field positions
   // ***********************************
   localparam int STS_VALID_BIT     = 7;
   localparam int CMD_READY_BIT     = 6;
   localparam int EXECUTE_BIT       = 5;
   localparam int RESP_AVAIL_BIT    = 4;
   localparam int EXPECT_BIT        = 3;
   localparam int SELF_TEST_BIT     = 2;
   localparam int RESP_RETRY_BIT    = 1;
   // ***********************************
   // data and sizing constants
   // ***********************************
   localparam logic [7:0] EMPTY_READ_VALUE = 8'h00_FF;
   localparam int         MIN_CMD_BYTES    = 10;
   localparam int         LEN_FIRST_BYTE   = 2;
   localparam int         LEN_LAST_BYTE    = 5;
   localparam int         CLK_PERIOD_NS    = 5;
   localparam int         READY_TIMEOUT_NS = 2000;
   localparam int         READY_TIMEOUT_CYC = READY_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam logic [7:0] STS_RESET        = 8'h0000;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READY,
      ST_RECEPTION,
      ST_EXECUTION,
      ST_COMPLETION
   } if_state_t;

   // one bus access from the host side
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       sel_data;   // 1 data port, 0 status register
      logic [7:0] wdata;
   } bus_req_t;
endpackage : fifo_if_pkg
`default_nettype wire

// ---- src/fifo_status_ctrl.sv ----
// status and data fifo control of the command interface
`default_nettype none
module fifo_status_ctrl
   import fifo_if_pkg::*;
#(
   parameter int DEPTH = 64,
   parameter int AW    = $clog2(DEPTH)
)(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire bus_req_t   bus_req,
   output logic            bus_wait,
   output logic [7:0]      bus_rdata,
   output logic            bus_rvalid,
   output logic            exec_start,
   input  wire logic       exec_done,
   input  wire logic       exec_abort_ack,
   output logic            exec_abort,
   output logic [AW-1:0]   cmd_len,
   input  wire logic       resp_we,
   input  wire logic [7:0] resp_wdata,
   input  wire logic       self_test_complete,
   output logic            state_ready
);
   // ***********************************
   // state and storage
   // ***********************************
   if_state_t     state_reg, state_next;
   logic [AW:0]   cmd_cnt_reg;
   logic [AW:0]   cmd_need_reg;
   logic [AW:0]   resp_wr_reg;
   logic [AW:0]   resp_rd_reg;
   logic          resp_avail_reg;
   logic          self_test_reg;
   logic          sts_valid_reg;
   logic          bus_wait_reg;
   logic [7:0]    bus_rdata_reg;
   logic          bus_rvalid_reg;
   logic          exec_start_reg;
   logic          exec_abort_reg;
   logic          state_ready_reg;
   logic [7:0]    cmd_rdata;
   logic [7:0]    resp_rdata;
   logic [15:0]   len_hi_reg;
   logic [$clog2(READY_TIMEOUT_CYC+1)-1:0] rdy_tmr_reg;

   // ***********************************
   // access decode
   // ***********************************
   wire sts_wr     = bus_req.wr && !bus_req.sel_data;
   wire sts_rd     = bus_req.rd && !bus_req.sel_data;
   wire data_wr    = bus_req.wr && bus_req.sel_data;
   wire data_rd    = bus_req.rd && bus_req.sel_data;
   wire wr_ready   = sts_wr && bus_req.wdata[CMD_READY_BIT];
   wire wr_exec    = sts_wr && bus_req.wdata[EXECUTE_BIT];
   wire wr_retry   = sts_wr && bus_req.wdata[RESP_RETRY_BIT];
   wire in_recv    = (state_reg == ST_RECEPTION);
   wire in_ready   = (state_reg == ST_READY);
   wire in_comp    = (state_reg == ST_COMPLETION);
   wire cmd_full   = (cmd_cnt_reg == (AW+1)'(DEPTH));
   wire cmd_accept = data_wr && (in_ready || in_recv) && !cmd_full;
   wire resp_have  = (resp_rd_reg != resp_wr_reg);
   wire resp_pop   = data_rd && in_comp && resp_avail_reg;
   wire fifos_empty = (cmd_cnt_reg == '0) && !resp_have;
   wire expect_on  = in_recv && (cmd_cnt_reg < cmd_need_reg);
   // a data write to a full command fifo in ready or reception is not stored and raises bus_wait the next cycle
   wire stall      = data_wr && (in_ready || in_recv) && cmd_full;
   wire abort_req  = wr_ready && (in_recv || state_reg == ST_EXECUTION);
   wire ready_tmo  = (rdy_tmr_reg == '0);

   // status byte as read: write-only bits read back zero
   wire [7:0] sts_byte = (8'(sts_valid_reg) << STS_VALID_BIT)
                       | (8'(in_ready) << CMD_READY_BIT)
                       | (8'(resp_avail_reg) << RESP_AVAIL_BIT)
                       | (8'(expect_on) << EXPECT_BIT)
                       | (8'(self_test_reg) << SELF_TEST_BIT);

   // data read returns all ones when nothing is available
   wire [7:0] data_byte = (resp_avail_reg) ? resp_rdata : EMPTY_READ_VALUE;

   // ***********************************
   // command and response buffers
   // ***********************************
   byte_store #(.DEPTH(DEPTH), .AW(AW)) cmd_store (
      .ref_clk (ref_clk),
      .we      (cmd_accept),
      .waddr   (cmd_cnt_reg[AW-1:0]),
      .wdata   (bus_req.wdata),
      .raddr   (AW'(0)),
      .rdata   (cmd_rdata)
   );

   byte_store #(.DEPTH(DEPTH), .AW(AW)) resp_store (
      .ref_clk (ref_clk),
      .we      (resp_we && state_reg == ST_EXECUTION),
      .waddr   (resp_wr_reg[AW-1:0]),
      .wdata   (resp_wdata),
      .raddr   (resp_rd_reg[AW-1:0]),
      .rdata   (resp_rdata)
   );

   // ***********************************
   // state machine
   // ***********************************
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE:
            if (wr_ready && fifos_empty)
               state_next = ST_READY;
         ST_READY:
            if (cmd_accept)
               state_next = ST_RECEPTION;
         ST_RECEPTION:
            if (abort_req)
               state_next = ST_IDLE;
            else if (wr_exec && !expect_on)
               state_next = ST_EXECUTION;
         ST_EXECUTION:
            if (abort_req || exec_abort_reg)
               state_next = exec_abort_ack ? ST_IDLE : ST_EXECUTION;
            else if (exec_done)
               state_next = ST_COMPLETION;
         ST_COMPLETION:
            if (wr_ready)
               state_next = ST_IDLE;
      endcase
      // idle heads to ready once the fifos are flushed, on a ready write or while the ready-entry window is open, else stays idle
      if (state_reg == ST_IDLE && rdy_tmr_reg != '0 && fifos_empty && !wr_ready)
         state_next = ST_READY;
   end

   // state register and ready-entry window
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_reg       <= ST_IDLE;
         state_ready_reg <= 1'b0;
         rdy_tmr_reg     <= '0;
      end
      else
      begin
         state_reg       <= state_next;
         state_ready_reg <= (state_next == ST_READY);
         if (wr_ready && (in_comp || state_reg == ST_IDLE))
            rdy_tmr_reg <= ($bits(rdy_tmr_reg))'(READY_TIMEOUT_CYC);
         // window closes once ready is reached or on abort, so a later idle stays idle
         else if (abort_req || in_ready)
            rdy_tmr_reg <= '0;
         else if (!ready_tmo)
            rdy_tmr_reg <= rdy_tmr_reg - 1'b1;
      end
   end

   // ***********************************
   // command fifo count and length
   // ***********************************
   always_ff @(posedge ref_clk)
   begin
      if (rst || abort_req || (wr_ready && in_comp))
      begin
         cmd_cnt_reg  <= '0;
         cmd_need_reg <= (AW+1)'(MIN_CMD_BYTES);
         len_hi_reg   <= '0;
      end
      else if (cmd_accept)
      begin
         cmd_cnt_reg <= cmd_cnt_reg + 1'b1;
         // length field sits big-endian in the header
         if (cmd_cnt_reg >= (AW+1)'(LEN_FIRST_BYTE) && cmd_cnt_reg < (AW+1)'(LEN_LAST_BYTE))
            len_hi_reg <= {len_hi_reg[7:0], bus_req.wdata};
         else if (cmd_cnt_reg == (AW+1)'(LEN_LAST_BYTE))
         begin
            if ({len_hi_reg, bus_req.wdata} > 24'(MIN_CMD_BYTES))
               cmd_need_reg <= ({len_hi_reg, bus_req.wdata} > 24'(DEPTH))
                             ? (AW+1)'(DEPTH) : (AW+1)'({len_hi_reg, bus_req.wdata});
         end
      end
   end

   // ***********************************
   // response pointers and availability
   // ***********************************
   always_ff @(posedge ref_clk)
   begin
      if (rst || (wr_ready && (in_comp || state_reg == ST_IDLE)) || abort_req)
      begin
         resp_wr_reg    <= '0;
         resp_rd_reg    <= '0;
         resp_avail_reg <= 1'b0;
      end
      else
      begin
         if (resp_we && state_reg == ST_EXECUTION)
            resp_wr_reg <= resp_wr_reg + 1'b1;
         if (wr_retry && in_comp)
         begin
            resp_rd_reg    <= '0;
            resp_avail_reg <= (resp_wr_reg != '0);
         end
         else if (resp_pop)
         begin
            resp_rd_reg    <= resp_rd_reg + 1'b1;
            resp_avail_reg <= (resp_rd_reg + 1'b1 != resp_wr_reg);
         end
         else
            resp_avail_reg <= in_comp && resp_have;
      end
   end

   // ***********************************
   // flags, execution handshake and bus answer
   // ***********************************
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         self_test_reg  <= 1'b0;
         sts_valid_reg  <= 1'b0;
         exec_start_reg <= 1'b0;
         exec_abort_reg <= 1'b0;
         bus_wait_reg   <= 1'b0;
         bus_rvalid_reg <= 1'b0;
         bus_rdata_reg  <= STS_RESET;
      end
      else
      begin
         // set by completion only; host writes cannot touch it
         self_test_reg  <= self_test_reg | self_test_complete;
         // flags settle one cycle after any access to the block
         sts_valid_reg  <= !(bus_req.wr || bus_req.rd);
         exec_start_reg <= in_recv && wr_exec && !expect_on;
         if (state_reg == ST_EXECUTION && abort_req)
            exec_abort_reg <= 1'b1;
         else if (exec_abort_ack || state_reg != ST_EXECUTION)
            exec_abort_reg <= 1'b0;
         bus_wait_reg   <= stall;
         bus_rvalid_reg <= sts_rd || data_rd;
         if (sts_rd)
            bus_rdata_reg <= sts_byte;
         else if (data_rd)
            bus_rdata_reg <= data_byte;
      end
   end

   assign bus_wait    = bus_wait_reg;
   assign bus_rdata   = bus_rdata_reg;
   assign bus_rvalid  = bus_rvalid_reg;
   assign exec_start  = exec_start_reg;
   assign exec_abort  = exec_abort_reg;
   assign cmd_len     = cmd_need_reg[AW-1:0];
   assign state_ready = state_ready_reg;
endmodule : fifo_status_ctrl
`default_nettype wire
